// ### logic/psr_sequencer.sv
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module psr_sequencer #(
	parameter int unsigned HOLD_CYCLES = 32'(psr_pkg::HOLD_WINDOW_CYC),
	parameter int unsigned STEP_CYCLES = 32'(psr_pkg::STEP_CYC),
	parameter int unsigned RES_N       = psr_pkg::RES_N
) (
	input  wire logic                           MCLK,
	input  wire logic                           RESET,
	input  wire psr_pkg::psr_axi_req_t          AXI_REQ,
	output psr_pkg::psr_axi_rsp_t               AXI_RSP,
	input  wire logic                           ON_REQUEST,
	input  wire logic                           HOST_HOLD_PIN,
	input  wire logic                           BOOT_SELECT_FIRST,
	input  wire logic                           BOOT_SELECT_SECOND,
	input  wire logic                           XTAL_STABLE,
	input  wire logic                           EXT_CLK_STABLE,
	input  wire logic                           ON_GATE,
	input  wire logic                           OTP_XTAL_ENABLE,
	input  wire logic                           OTP_OSC_BYPASS,
	input  wire logic                           OTP_GATE_BYPASS,
	input  wire logic                           OTP_AUTO_MODE,
	input  wire logic                           OTP_AUTO_SET,
	input  wire logic [psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0]     OTP_VOLTAGE_SELECT_FIELD_SET0,
	input  wire logic [psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0]     OTP_VOLTAGE_SELECT_FIELD_SET1,
	output logic                                PROC_RESET_N,
	output logic [RES_N-1:0]                    RESOURCE_EN,
	output logic [1:0]                          SEQ_SELECT,
	output logic                                CONFIG_SET,
	output logic [psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0]          NORMAL_VOLTAGE_SELECT_FIELD,
	output logic [psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0]          FORCED_VOLTAGE_SELECT_FIELD
);

	localparam int STP_W  = (RES_N > 1) ? $clog2(RES_N) : 1;
	localparam int STEP_W = $clog2(STEP_CYCLES + 1);
	localparam int HOLD_W = $clog2(HOLD_CYCLES + 64'd1);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [psr_pkg::PIN_N-1:0] pin_s1, pin_s2, pin_s3, pin_f, pins;
	psr_pkg::psr_state_t       st;
	logic [STP_W-1:0]          step, last;
	logic [STEP_W-1:0]         step_tmr;
	logic [HOLD_W-1:0]         hold_cnt;
	logic                      step_tick, hold_done, keep, keep_prev, off_req;
	logic                      clk_ok, start, pdn_end, restart_pend, voltage_select_field_pend;
	logic                      keep_bit, auto_mode, auto_set, off_hard, off_cold;
	logic [1:0]                last_level;
	logic                      aw_full, w_full, r_busy, next_aw_full, next_w_full;
	logic                      next_r_busy, wr_fire, wr_en;
	logic [psr_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0]               w_data;
	logic [3:0]                w_strb;
	logic                      awready, wready, bvalid, arready, rvalid;
	logic [1:0]                bresp, rresp;
	logic [31:0]               rdata, rd_val;

	assign AXI_RSP = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
		arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic addr_ok(input logic [psr_pkg::ADDR_W-1:0] a);
		addr_ok = (a == psr_pkg::OFS_CTRL) || (a == psr_pkg::OFS_OFFCFG) ||
			(a == psr_pkg::OFS_STATUS) || (a == psr_pkg::OFS_NORMV) ||
			(a == psr_pkg::OFS_FORCEV) || (a == psr_pkg::OFS_RESEN);
	endfunction

	function automatic logic [STP_W-1:0] seq_last(input logic [1:0] sel, input logic b1);
		case (sel)
			psr_pkg::SEL_0: seq_last = STP_W'(RES_N - 1);
			psr_pkg::SEL_1: seq_last = STP_W'(RES_N - 2);
			default:        seq_last = b1 ? STP_W'(RES_N - 1) : STP_W'(RES_N - 2);
		endcase
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	assign pins = {ON_GATE, EXT_CLK_STABLE, XTAL_STABLE, BOOT_SELECT_SECOND,
		BOOT_SELECT_FIRST, HOST_HOLD_PIN, ON_REQUEST};

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f  <= '0;
		end
		else
		begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
		end
	end

	// ----------------------------------------
	// Boot selection
	// ----------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			CONFIG_SET <= 1'b0;
			SEQ_SELECT <= psr_pkg::SEL_0;
		end
		else
		begin
			CONFIG_SET <= pin_f[psr_pkg::PIN_BOOT_SELECT_FIRST];
			if (pin_f[psr_pkg::PIN_BOOT_SELECT_FIRST])
				SEQ_SELECT <= psr_pkg::SEL_2;
			else if (pin_f[psr_pkg::PIN_BOOT_SELECT_SECOND])
				SEQ_SELECT <= psr_pkg::SEL_1;
			else
				SEQ_SELECT <= psr_pkg::SEL_0;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign last      = seq_last(SEQ_SELECT, pin_f[psr_pkg::PIN_BOOT_SELECT_SECOND]);
	assign step_tick = (step_tmr == STEP_W'(STEP_CYCLES - 1));
	assign hold_done = (hold_cnt == HOLD_W'(HOLD_CYCLES));
	assign keep      = pin_f[psr_pkg::PIN_HOLD] | keep_bit;
	assign off_req   = (keep_prev && !keep) || (hold_done && !keep);
	assign clk_ok    = OTP_GATE_BYPASS ||
		(OTP_OSC_BYPASS ? pin_f[psr_pkg::PIN_EXT] :
		(!OTP_XTAL_ENABLE || pin_f[psr_pkg::PIN_XTAL]));
	assign start     = (st == psr_pkg::PSR_OFF) && !pin_f[psr_pkg::PIN_GATE] &&
		(pin_f[psr_pkg::PIN_ON] || restart_pend);
	assign pdn_end   = (st == psr_pkg::PSR_PDN) && step_tick && (step == '0);

	always_ff @(posedge MCLK)
	begin
		if (RESET)
			st <= psr_pkg::PSR_OFF;
		else
			case (st)
				psr_pkg::PSR_OFF:  if (start) st <= psr_pkg::PSR_PUP;
				psr_pkg::PSR_PUP:  if (step_tick && step >= last) st <= psr_pkg::PSR_CLKW;
				psr_pkg::PSR_CLKW: if (clk_ok) st <= psr_pkg::PSR_ACT;
				psr_pkg::PSR_ACT:  if (off_req) st <= psr_pkg::PSR_PDN;
				psr_pkg::PSR_PDN:  if (pdn_end) st <= psr_pkg::PSR_OFF;
				default:           st <= psr_pkg::PSR_OFF;
			endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || start || st == psr_pkg::PSR_CLKW || st == psr_pkg::PSR_ACT)
			step_tmr <= '0;
		else if (step_tick)
			step_tmr <= '0;
		else if (st != psr_pkg::PSR_OFF)
			step_tmr <= step_tmr + STEP_W'(1);
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || start)
			step <= '0;
		else if (st == psr_pkg::PSR_PUP && step_tick && step < last)
			step <= step + STP_W'(1);
		else if (st == psr_pkg::PSR_PDN && step_tick && step != '0)
			step <= step - STP_W'(1);
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || st != psr_pkg::PSR_ACT)
			hold_cnt <= '0;
		else if (!hold_done)
			hold_cnt <= hold_cnt + HOLD_W'(1);
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
			keep_prev <= 1'b0;
		else
			keep_prev <= (st == psr_pkg::PSR_ACT) && keep;
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
			PROC_RESET_N <= 1'b0;
		else if (st == psr_pkg::PSR_CLKW && clk_ok)
			PROC_RESET_N <= 1'b1;
		else if (st != psr_pkg::PSR_ACT || off_req)
			PROC_RESET_N <= 1'b0;
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
			restart_pend <= 1'b0;
		else if (pdn_end)
			restart_pend <= off_cold;
		else if (start)
			restart_pend <= 1'b0;
	end

	// ----------------------------------------
	// Registers by reset domain
	// ----------------------------------------
	assign wr_en = wr_fire && w_strb[0];

	always_ff @(posedge MCLK)
	begin
		if (RESET || pdn_end)
			RESOURCE_EN <= '0;
		else if (st == psr_pkg::PSR_PUP && step_tick)
			RESOURCE_EN[step] <= 1'b1;
		else if (st == psr_pkg::PSR_PDN && step_tick)
			RESOURCE_EN[step] <= 1'b0;
		else if (wr_en && aw_addr == psr_pkg::OFS_RESEN &&
			(st == psr_pkg::PSR_ACT || st == psr_pkg::PSR_OFF))
			RESOURCE_EN <= w_data[RES_N-1:0];
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || pdn_end)
			keep_bit <= 1'b0;
		else if (st == psr_pkg::PSR_CLKW && clk_ok && auto_mode && auto_set)
			keep_bit <= 1'b1;
		else if (wr_en && aw_addr == psr_pkg::OFS_CTRL)
			keep_bit <= w_data[psr_pkg::CTRL_KEEP];
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || (pdn_end && off_hard))
		begin
			auto_mode <= OTP_AUTO_MODE;
			auto_set  <= OTP_AUTO_SET;
		end
		else if (wr_en && aw_addr == psr_pkg::OFS_CTRL)
		begin
			auto_mode <= w_data[psr_pkg::CTRL_AUTO_MODE];
			auto_set  <= w_data[psr_pkg::CTRL_AUTO_SET];
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			off_hard <= 1'b0;
			off_cold <= 1'b0;
		end
		else if (wr_en && aw_addr == psr_pkg::OFS_OFFCFG)
		begin
			off_hard <= w_data[psr_pkg::OFF_HARD];
			off_cold <= w_data[psr_pkg::OFF_COLD];
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
			last_level <= psr_pkg::LVL_0;
		else if (pdn_end)
			last_level <= off_hard ? psr_pkg::LVL_1 : psr_pkg::LVL_2;
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET || pdn_end)
			voltage_select_field_pend <= 1'b1;
		else if (start)
			voltage_select_field_pend <= 1'b0;
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			NORMAL_VOLTAGE_SELECT_FIELD <= '0;
			FORCED_VOLTAGE_SELECT_FIELD <= '0;
		end
		else if (start && voltage_select_field_pend)
		begin
			NORMAL_VOLTAGE_SELECT_FIELD <= pin_f[psr_pkg::PIN_BOOT_SELECT_FIRST] ? OTP_VOLTAGE_SELECT_FIELD_SET1 : OTP_VOLTAGE_SELECT_FIELD_SET0;
			FORCED_VOLTAGE_SELECT_FIELD <= pin_f[psr_pkg::PIN_BOOT_SELECT_FIRST] ? OTP_VOLTAGE_SELECT_FIELD_SET1 : OTP_VOLTAGE_SELECT_FIELD_SET0;
		end
		else if (wr_en && aw_addr == psr_pkg::OFS_NORMV)
			NORMAL_VOLTAGE_SELECT_FIELD <= w_data[psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0];
		else if (wr_en && aw_addr == psr_pkg::OFS_FORCEV)
			FORCED_VOLTAGE_SELECT_FIELD <= w_data[psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0];
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign next_aw_full = (aw_full || (AXI_REQ.awvalid && awready)) && !(bvalid && AXI_REQ.bready);
	assign next_w_full  = (w_full || (AXI_REQ.wvalid && wready)) && !(bvalid && AXI_REQ.bready);
	assign next_r_busy  = (r_busy || (AXI_REQ.arvalid && arready)) && !(rvalid && AXI_REQ.rready);
	assign wr_fire      = aw_full && w_full && !bvalid && addr_ok(aw_addr);

	always_comb
	begin
		rd_val = '0;
		case (AXI_REQ.araddr)
			psr_pkg::OFS_CTRL:
			begin
				rd_val[psr_pkg::CTRL_KEEP]      = keep_bit;
				rd_val[psr_pkg::CTRL_AUTO_MODE] = auto_mode;
				rd_val[psr_pkg::CTRL_AUTO_SET]  = auto_set;
			end
			psr_pkg::OFS_OFFCFG:
			begin
				rd_val[psr_pkg::OFF_HARD] = off_hard;
				rd_val[psr_pkg::OFF_COLD] = off_cold;
			end
			psr_pkg::OFS_STATUS:
			begin
				rd_val[psr_pkg::ST_STATE +: 3] = 3'(st);
				rd_val[psr_pkg::ST_PRST]       = PROC_RESET_N;
				rd_val[psr_pkg::ST_SEL +: 2]   = SEQ_SELECT;
				rd_val[psr_pkg::ST_CFG]        = CONFIG_SET;
				rd_val[psr_pkg::ST_LVL +: 2]   = last_level;
			end
			psr_pkg::OFS_NORMV:  rd_val[psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0] = NORMAL_VOLTAGE_SELECT_FIELD;
			psr_pkg::OFS_FORCEV: rd_val[psr_pkg::VOLTAGE_SELECT_FIELD_W-1:0] = FORCED_VOLTAGE_SELECT_FIELD;
			psr_pkg::OFS_RESEN:  rd_val[RES_N-1:0] = RESOURCE_EN;
			default:             rd_val = '0;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= psr_pkg::RESP_OKAY;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
			awready <= !next_aw_full;
			wready  <= !next_w_full;
			if (AXI_REQ.awvalid && awready)
				aw_addr <= AXI_REQ.awaddr;
			if (AXI_REQ.wvalid && wready)
			begin
				w_data <= AXI_REQ.wdata;
				w_strb <= AXI_REQ.wstrb;
			end
			if (aw_full && w_full && !bvalid)
			begin
				bvalid <= 1'b1;
				bresp  <= addr_ok(aw_addr) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_DECERR;
			end
			else if (AXI_REQ.bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			r_busy  <= 1'b0;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= psr_pkg::RESP_OKAY;
		end
		else
		begin
			r_busy  <= next_r_busy;
			arready <= !next_r_busy;
			if (AXI_REQ.arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_val;
				rresp  <= addr_ok(AXI_REQ.araddr) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_DECERR;
			end
			else if (AXI_REQ.rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	property p_release_cause;
		$rose(PROC_RESET_N) |-> $past(st == psr_pkg::PSR_CLKW && clk_ok);
	endproperty
	a_release_cause: assert property (p_release_cause) else $error("Reset released early");

	property p_gate_bypass;
		(st == psr_pkg::PSR_CLKW && OTP_GATE_BYPASS) |=> PROC_RESET_N && st == psr_pkg::PSR_ACT;
	endproperty
	a_gate_bypass: assert property (p_gate_bypass) else $error("Bypass did not release");

	property p_low_in_seq;
		(st == psr_pkg::PSR_PUP || st == psr_pkg::PSR_CLKW) |-> !PROC_RESET_N;
	endproperty
	a_low_in_seq: assert property (p_low_in_seq) else $error("Reset high in sequence");

	property p_auto_set;
		($rose(PROC_RESET_N) && auto_mode && auto_set) |-> keep_bit;
	endproperty
	a_auto_set: assert property (p_auto_set) else $error("Keep bit not auto set");

	property p_hold_fall;
		(st == psr_pkg::PSR_ACT && keep_prev && !keep) |=> st == psr_pkg::PSR_PDN && !PROC_RESET_N;
	endproperty
	a_hold_fall: assert property (p_hold_fall) else $error("Hold drop ignored");

	property p_window;
		(st == psr_pkg::PSR_ACT && hold_done && !keep) |=> st == psr_pkg::PSR_PDN;
	endproperty
	a_window: assert property (p_window) else $error("No shutdown after window");

	property p_seq_sel;
		pin_f[psr_pkg::PIN_BOOT_SELECT_FIRST] |=> SEQ_SELECT == psr_pkg::SEL_2 && CONFIG_SET;
	endproperty
	a_seq_sel: assert property (p_seq_sel) else $error("Boot selection wrong");

	property p_voltage_select_field_same;
		(start && voltage_select_field_pend) |=> NORMAL_VOLTAGE_SELECT_FIELD == FORCED_VOLTAGE_SELECT_FIELD;
	endproperty
	a_voltage_select_field_same: assert property (p_voltage_select_field_same) else $error("Voltage fields differ");

	property p_level1;
		(pdn_end && off_hard) |=> last_level == psr_pkg::LVL_1 && RESOURCE_EN == '0
			&& off_hard == $past(off_hard) && !keep_bit;
	endproperty
	a_level1: assert property (p_level1) else $error("Hard reset level wrong");

	property p_level2;
		(pdn_end && !off_hard) |=> last_level == psr_pkg::LVL_2 && !keep_bit
			&& auto_mode == $past(auto_mode) && auto_set == $past(auto_set);
	endproperty
	a_level2: assert property (p_level2) else $error("Switch-off level wrong");

	property p_cold;
		(pdn_end && off_cold) ##1 !pin_f[psr_pkg::PIN_GATE] |=> st == psr_pkg::PSR_PUP;
	endproperty
	a_cold: assert property (p_cold) else $error("Cold restart missing");

	c_release:  cover property ($rose(PROC_RESET_N));
	c_shutdown: cover property (pdn_end && !off_cold);
	c_cold:     cover property (pdn_end && off_cold);
	c_write:    cover property (wr_en && aw_addr == psr_pkg::OFS_CTRL);

endmodule // psr_sequencer

// ### logic/psr_pkg.sv
package psr_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ          = 125_000_000;
	localparam longint HOLD_WINDOW_S   = 8;
	localparam longint HOLD_WINDOW_CYC = HOLD_WINDOW_S * CLK_HZ;
	localparam longint STEP_TIME_US    = 100;
	localparam longint STEP_CYC        = (STEP_TIME_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int     RES_N           = 6;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_OFFCFG   = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_NORMV    = 8'h0C;
	localparam logic [7:0] OFS_FORCEV   = 8'h10;
	localparam logic [7:0] OFS_RESEN    = 8'h14;

	localparam int CTRL_KEEP      = 0;
	localparam int CTRL_AUTO_MODE = 1;
	localparam int CTRL_AUTO_SET  = 2;
	localparam int OFF_HARD       = 0;
	localparam int OFF_COLD       = 1;
	localparam int ST_STATE       = 0;
	localparam int ST_PRST        = 3;
	localparam int ST_SEL         = 4;
	localparam int ST_CFG         = 6;
	localparam int ST_LVL         = 7;
	localparam int VOLTAGE_SELECT_FIELD_W         = 7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [1:0] SEL_0 = 2'h0;
	localparam logic [1:0] SEL_1 = 2'h1;
	localparam logic [1:0] SEL_2 = 2'h2;
	localparam logic [1:0] LVL_0 = 2'h0;
	localparam logic [1:0] LVL_1 = 2'h1;
	localparam logic [1:0] LVL_2 = 2'h2;

	localparam int PIN_ON    = 0;
	localparam int PIN_HOLD  = 1;
	localparam int PIN_BOOT_SELECT_FIRST = 2;
	localparam int PIN_BOOT_SELECT_SECOND = 3;
	localparam int PIN_XTAL  = 4;
	localparam int PIN_EXT   = 5;
	localparam int PIN_GATE  = 6;
	localparam int PIN_N     = 7;

	typedef enum {PSR_OFF, PSR_PUP, PSR_CLKW, PSR_ACT, PSR_PDN} psr_state_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} psr_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} psr_axi_rsp_t;

endpackage

// ### test/psr_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host processor hold behaviour
// ----------------------------------------
module psr_host_model #(
	parameter int unsigned DELAY = 20
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic proc_reset_n,
	input  wire logic hold_enable,
	output logic      host_hold_pin
);
	int unsigned dly;

	always_ff @(posedge clk)
	begin
		if (rst || !proc_reset_n)
			dly <= 0;
		else if (dly < DELAY)
			dly <= dly + 1;
	end

	// Raise within the window, keep while wanted
	always_ff @(posedge clk)
		host_hold_pin <= !rst && proc_reset_n && hold_enable && (dly >= DELAY);
endmodule // psr_host_model

// ### test/psr_sequencer_bench.sv
`timescale 1ns/100ps

module psr_sequencer_bench;
	// ----------------------------------------
	// Stimulus and checks
	// ----------------------------------------
	logic MCLK = 0, RESET = 1, ON_REQUEST = 0, XTAL_STABLE = 0, B0 = 0, B1 = 0;
	logic AUTO = 0, HOLD_EN = 0, HOLD;
	logic EXT = 0, GATE = 0, OSCB = 0, GATEB = 0, ASET = 1;
	logic [5:0]  RES;
	logic [6:0]  VSEL0 = '0, VSEL1 = '0;
	logic [31:0] seed = 32'hDC3D1676, d;
	logic [1:0]  r;
	logic PROC_RESET_N, CONFIG_SET;
	logic [1:0]  SEQ_SELECT;
	logic [6:0]  NORMAL_VOLTAGE_SELECT_FIELD, FORCED_VOLTAGE_SELECT_FIELD;
	int miscompares = 0, total_checks = 0;
	psr_pkg::psr_axi_req_t req = '0;
	psr_pkg::psr_axi_rsp_t rsp;

	always #4 MCLK = ~MCLK;

	psr_sequencer #(.HOLD_CYCLES(200), .STEP_CYCLES(4)) i_dut (.MCLK(MCLK), .RESET(RESET),
		.AXI_REQ(req), .AXI_RSP(rsp), .ON_REQUEST(ON_REQUEST), .HOST_HOLD_PIN(HOLD),
		.BOOT_SELECT_FIRST(B0), .BOOT_SELECT_SECOND(B1), .XTAL_STABLE(XTAL_STABLE),
		.EXT_CLK_STABLE(EXT), .ON_GATE(GATE), .OTP_XTAL_ENABLE(1'b1), .OTP_OSC_BYPASS(OSCB),
		.OTP_GATE_BYPASS(GATEB), .OTP_AUTO_MODE(AUTO), .OTP_AUTO_SET(ASET),
		.OTP_VOLTAGE_SELECT_FIELD_SET0(VSEL0), .OTP_VOLTAGE_SELECT_FIELD_SET1(VSEL1), .PROC_RESET_N(PROC_RESET_N),
		.RESOURCE_EN(RES), .SEQ_SELECT(SEQ_SELECT), .CONFIG_SET(CONFIG_SET),
		.NORMAL_VOLTAGE_SELECT_FIELD(NORMAL_VOLTAGE_SELECT_FIELD), .FORCED_VOLTAGE_SELECT_FIELD(FORCED_VOLTAGE_SELECT_FIELD));

	psr_host_model i_host (.clk(MCLK), .rst(RESET), .proc_reset_n(PROC_RESET_N),
		.hold_enable(HOLD_EN), .host_hold_pin(HOLD));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [1:0] exp_sel(input logic b0, input logic b1);
		return b0 ? psr_pkg::SEL_2 : (b1 ? psr_pkg::SEL_1 : psr_pkg::SEL_0);
	endfunction

	function automatic logic [5:0] exp_res(input logic b0, input logic b1);
		return (b0 == b1) ? 6'h3F : 6'h1F;
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (PROC_RESET_N !== v && n < 80)
		begin
			@(posedge MCLK);
			n++;
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] dat);
		logic aw, w;
		aw = 0;
		w = 0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= dat;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge MCLK);
			if (!aw && rsp.awready === 1'b1)
			begin
				aw = 1;
				req.awvalid <= 1'b0;
			end
			if (!w && rsp.wready === 1'b1)
			begin
				w = 1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge MCLK); while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(posedge MCLK); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge MCLK); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	task automatic up(input logic b0, input logic b1, input logic am);
		seed = lfsr(seed);
		RESET <= 1'b1;
		AUTO <= am;
		B0 <= b0;
		B1 <= b1;
		XTAL_STABLE <= 1'b0;
		EXT <= 1'b0;
		GATE <= 1'b0;
		VSEL0 <= seed[6:0];
		VSEL1 <= seed[14:8];
		repeat (10) @(posedge MCLK);
		RESET <= 1'b0;
		repeat (4) @(posedge MCLK);
		ON_REQUEST <= 1'b1;
		repeat (80) @(posedge MCLK);
		ON_REQUEST <= 1'b0;
		chk(PROC_RESET_N, GATEB);
		XTAL_STABLE <= 1'b1;
		repeat (8) @(posedge MCLK);
		chk(PROC_RESET_N, GATEB | !OSCB);
		EXT <= 1'b1;
		wait_rst(1'b1);
		chk(PROC_RESET_N, 1'b1);
		chk(RES, exp_res(b0, b1));
		chk(SEQ_SELECT, exp_sel(b0, b1));
		chk(CONFIG_SET, b0);
		chk(NORMAL_VOLTAGE_SELECT_FIELD, b0 ? VSEL1 : VSEL0);
		chk(FORCED_VOLTAGE_SELECT_FIELD, b0 ? VSEL1 : VSEL0);
	endtask

	initial
	begin
		repeat (60000) @(posedge MCLK);
		miscompares++;
		test_done;
	end

	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			up(i[1], i[0], 1'b0);
			HOLD_EN <= i[0];
			repeat (150) @(posedge MCLK);
			chk(PROC_RESET_N, 1'b1);
			repeat (150) @(posedge MCLK);
			chk(PROC_RESET_N, i[0]);
			HOLD_EN <= 1'b0;
			wait_rst(1'b0);
			chk(PROC_RESET_N, 1'b0);
		end
		OSCB <= 1'b1;
		up(seed[3], seed[5], 1'b1);
		axr(psr_pkg::OFS_CTRL);
		chk(d[0], 1'b1);
		repeat (300) @(posedge MCLK);
		chk(PROC_RESET_N, 1'b1);
		axw(psr_pkg::OFS_CTRL, 32'h00000006);
		wait_rst(1'b0);
		chk(PROC_RESET_N, 1'b0);
		repeat (40) @(posedge MCLK);
		axr(psr_pkg::OFS_STATUS);
		chk(d[2:0], 3'h0);
		chk(d[8:7], psr_pkg::LVL_2);
		chk(RES, 6'h00);
		OSCB <= 1'b0;
		GATEB <= 1'b1;
		ASET <= 1'b0;
		up(1'b1, 1'b0, 1'b1);
		axr(psr_pkg::OFS_CTRL);
		chk(d[2:0], 3'h2);
		axw(psr_pkg::OFS_CTRL, 32'h00000003);
		axr(psr_pkg::OFS_STATUS);
		chk(d[8:7], psr_pkg::LVL_0);
		axw(psr_pkg::OFS_OFFCFG, 32'h00000003);
		axw(psr_pkg::OFS_NORMV, {25'h0, VSEL1 ^ 7'h55});
		axr(psr_pkg::OFS_NORMV);
		chk(d[6:0], VSEL1 ^ 7'h55);
		repeat (300) @(posedge MCLK);
		chk(PROC_RESET_N, 1'b1);
		GATE <= 1'b1;
		axw(psr_pkg::OFS_CTRL, 32'h00000000);
		wait_rst(1'b0);
		chk(PROC_RESET_N, 1'b0);
		repeat (60) @(posedge MCLK);
		chk(RES, 6'h00);
		axr(psr_pkg::OFS_STATUS);
		chk(d[2:0], 3'h0);
		chk(d[8:7], psr_pkg::LVL_1);
		axr(psr_pkg::OFS_CTRL);
		chk(d[2:0], 3'h2);
		axr(psr_pkg::OFS_OFFCFG);
		chk(d[1:0], 2'h3);
		GATE <= 1'b0;
		wait_rst(1'b1);
		chk(PROC_RESET_N, 1'b1);
		chk(NORMAL_VOLTAGE_SELECT_FIELD, VSEL1);
		repeat (220) @(posedge MCLK);
		chk(PROC_RESET_N, 1'b0);
		wait_rst(1'b1);
		chk(PROC_RESET_N, 1'b1);
		axr(8'h40);
		chk({r, d}, {psr_pkg::RESP_DECERR, 32'h00000000});
		test_done;
	end
endmodule // psr_sequencer_bench
